// file: test_telemetry_rate_scheduler.sv
/*
 testbench: enables one packet group at a time over wishbone and matches
 each accepted descriptor and each read against queued notes.
 assumes TICK_DIV of 10, so a rate R fires every 20400/R clocks.
*/
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module test_telemetry_rate_scheduler;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [9:0]  adr_i = '0;
  logic [31:0] dat_i = '0, dat_o, p, s;
  logic [3:0]  sel_i = 4'hF, pkt_len_o;
  logic [7:0]  pkt_addr_o, r;
  logic        ack_o, err_o, pkt_valid_o, pkt_ready_i, pkt_batch_o;
  int          error_cnt = 0, check_count = 0;
  logic [12:0] pq[$];
  logic [31:0] rq[$];
  // {start register, length, batch} per row
  logic [12:0] exp_tab[7] = '{13'hDA7, 13'hE0B, 13'hEA9, 13'hF29, 13'hE13, 13'hAA2, 13'hAA2};
  int          k_tab[7] = '{2, 2, 2, 2, 2, 2, 1};

  always #10 clk_i = ~clk_i;

  trs_scheduler #(.TICK_DIV(10)) u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .err_o, .pkt_valid_o, .pkt_ready_i, .pkt_addr_o,
    .pkt_len_o, .pkt_batch_o);
  trs_host_model u_host (.clk_i, .rst_i, .pkt_valid_i(pkt_valid_o), .pkt_ready_o(pkt_ready_i));

  // ----------------------------------------
  // watcher
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (!rst_i && pkt_valid_o && pkt_ready_i) begin
      if (pq.size() == 0) `CHK("stray packet", 13'bx, {pkt_addr_o, pkt_len_o, pkt_batch_o})
      else `CHK("packet", pq.pop_front(), {pkt_addr_o, pkt_len_o, pkt_batch_o})
    end
    if (ack_o && !we_i) `CHK("read data", rq.pop_front(), dat_o)
  end

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d, input logic e);
    int n = 0;
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (!ack_o && !err_o && n < 50);
    `CHK("bus error flag", e, err_o)
    {cyc_i, stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask : wb

  task automatic rd(input logic [9:0] a, input logic [31:0] x);
    rq.push_back(x);
    wb(1'b0, a, 32'h0, 1'b0);
  endtask : rd

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    void'($urandom(33));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(10'h014, 32'h0);
    rd(10'h018, 32'h0);
    wb(1'b0, 10'h3FC, 32'h0, 1'b1);
    for (int i = 0; i < 7; i++) begin
      // reserved bits always random: they must change nothing
      r = 8'($urandom_range(255, 64));
      p = {8'h00, 4'($urandom), 4'h0, 16'($urandom)};
      s = 32'h0;
      case (i)
        0: s = {r, 24'h0};
        1: s = {8'h0, r, 16'h0};
        2: s = {16'h0, r, 8'h0};
        3: s = {24'h0, r};
        4: begin p[31:24] = r; s = 32'h00FF_FF00; end
        5: p[19:16] = 4'h6;
        default: p[19:16] = 4'hF;
      endcase
      repeat (k_tab[i]) pq.push_back(exp_tab[i]);
      wb(1'b1, 10'h018, p, 1'b0);
      wb(1'b1, 10'h014, s, 1'b0);
      rd(10'h014, s);
      rd(10'h018, p & 32'hFF0F_0000);
      for (int n = 0; n < 25000 && pq.size() > 0; n++) @(posedge clk_i);
      `CHK("packets left", 0, pq.size())
      // estimates first, so an uncovered euler group never fires
      wb(1'b1, 10'h014, 32'h0, 1'b0);
      wb(1'b1, 10'h018, 32'h0, 1'b0);
      repeat (400) @(posedge clk_i);
    end
    close_out();
  end

  initial begin
    repeat (90000) @(posedge clk_i);
    error_cnt++;
    close_out();
  end
endmodule : test_telemetry_rate_scheduler

// file: trs_host_model.sv
/*
 host-side framer model: takes packet descriptors with random stalls.
 assumes the scheduler's clock and its synchronous active-high reset.
*/
module trs_host_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // descriptor handshake
  input  wire logic pkt_valid_i,
  output logic      pkt_ready_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // stall pattern
  // ----------------------------------------
  // ready comes late and at random, so valid must hold across slow answers
  always @(posedge clk_i) begin
    if (rst_i) begin
      pkt_ready_o <= 1'b0;
    end else begin
      pkt_ready_o <= pkt_valid_i && (($urandom % 3) != 0);
    end
  end
endmodule : trs_host_model

// file: trs_pkg.sv
/*
 telemetry rate scheduler package: register indices, field positions,
 reset values, packet descriptors and timing counts.
 assumes a 50 MHz system clock and a 32-bit classic wishbone slave.
*/
package trs_pkg;

  // ----------------------------------------
  // register map (printed offsets are indices)
  // ----------------------------------------
  localparam logic [7:0]  REG_IDX_ESTIMATES   = 8'h05;
  localparam logic [7:0]  REG_IDX_POSE_STATUS = 8'h06;
  localparam logic [7:0]  REG_IDX_STATUS      = 8'h07;
  localparam logic [31:0] RST_ESTIMATES       = 32'h0000_0000;
  localparam logic [31:0] RST_POSE_STATUS     = 32'h0000_0000;
  localparam logic [31:0] POSE_STATUS_WMASK   = 32'hFF0F_0000;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int QUAT_LSB   = 24;
  localparam int EULER_LSB  = 16;
  localparam int POSN_LSB   = 8;
  localparam int VELO_LSB   = 0;
  localparam int POSE_LSB   = 24;
  localparam int HEALTH_LSB = 16;

  // ----------------------------------------
  // packet descriptors
  // ----------------------------------------
  localparam int NUM_GROUPS = 6;
  localparam int GRP_QUAT   = 0;
  localparam int GRP_EULER  = 1;
  localparam int GRP_POSN   = 2;
  localparam int GRP_VELO   = 3;
  localparam int GRP_POSE   = 4;
  localparam int GRP_HEALTH = 5;

  localparam logic [7:0] ADDR_QUAT   = 8'h6D;  // 109
  localparam logic [7:0] ADDR_EULER  = 8'h70;  // 112
  localparam logic [7:0] ADDR_POSN   = 8'h75;  // 117
  localparam logic [7:0] ADDR_VELO   = 8'h79;  // 121
  localparam logic [7:0] ADDR_POSE   = 8'h70;  // 112
  localparam logic [7:0] ADDR_HEALTH = 8'h55;  // 85
  localparam logic [3:0] LEN_QUAT    = 4'h3;
  localparam logic [3:0] LEN_EULER   = 4'h5;
  localparam logic [3:0] LEN_POSN    = 4'h4;
  localparam logic [3:0] LEN_VELO    = 4'h4;
  localparam logic [3:0] LEN_POSE    = 4'h9;
  localparam logic [3:0] LEN_HEALTH  = 4'h1;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ        = 50_000_000;
  // time base tick: rates are in Hz, the tick runs at 8 * 255 Hz base grid
  localparam int TICK_HZ       = 2040;
  localparam int TICK_CYCLES   = CLK_HZ / TICK_HZ;
  // health period in ticks for codes 1..6 (8 s down to 0.25 s)
  localparam logic [15:0] HP_0125 = 16'd16320;
  localparam logic [15:0] HP_025  = 16'd8160;
  localparam logic [15:0] HP_05   = 16'd4080;
  localparam logic [15:0] HP_1    = 16'd2040;
  localparam logic [15:0] HP_2    = 16'd1020;
  localparam logic [15:0] HP_4    = 16'd510;

endpackage : trs_pkg

// file: trs_rate_gen.sv
/*
 one rate generator: fractional accumulator that fires evenly spaced
 requests at a given rate against a common tick.
 assumes tick_i is a one-cycle enable from the same clock.
*/
module trs_rate_gen #(
  parameter int ACC_W = 16
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // time base
  input  wire logic             tick_i,
  // rate: add inc_i per tick, fire at modulus
  input  wire logic [ACC_W-1:0] inc_i,
  input  wire logic [ACC_W-1:0] mod_i,
  input  wire logic             en_i,
  // request
  output logic                  fire_o
);

  logic [ACC_W:0] acc_reg;
  logic [ACC_W:0] sum;
  wire            hit = (sum >= {1'b0, mod_i});

  assign sum = acc_reg + {1'b0, inc_i};

  // a disabled group holds its phase at zero so re-enabling restarts cleanly
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      acc_reg <= '0;
      fire_o  <= 1'b0;
    end else begin
      fire_o <= tick_i && hit;
      if (tick_i) begin
        acc_reg <= hit ? sum - {1'b0, mod_i} : sum;
      end
    end
  end

endmodule : trs_rate_gen

// file: trs_scheduler.sv
/*
 telemetry rate scheduler: two rate registers on a wishbone slave, a
 common time base, one rate generator per packet group and a pending
 queue that hands packet descriptors to the packet framer.
 assumes a single 50 MHz clock, synchronous reset and a framer that
 takes one descriptor per pkt_valid_o/pkt_ready_i handshake.
*/
// Notes on behaviour
// - zero rate field sends no packet
// - estimates bits 31:24 quaternion rate, Hz
// - estimates bits 23:16 euler rate, Hz
// - estimates bits 15:8 position rate, Hz
// - estimates bits 7:0 velocity rate, Hz
// - quaternion batch of three from 109
// - euler batch of five from 112
// - position batch of four from 117
// - velocity batch of four from 121
// - nonzero pose rate suppresses euler and position
// - pose status bits 31:24 pose rate
// - health code 0 off, 1..6 scale, else 1Hz
// - pose batch of nine from 112
// - health single packet, register 85
// - reserved pose status bits have no effect
module trs_scheduler
  import trs_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  output logic             err_o,
  // packet descriptor stream to framer
  output logic             pkt_valid_o,
  input  wire logic        pkt_ready_i,
  output logic [7:0]       pkt_addr_o,
  output logic [3:0]       pkt_len_o,
  output logic             pkt_batch_o
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction : byte_merge

  function automatic logic [15:0] health_period(input logic [3:0] code);
    logic [15:0] p;
    case (code)
      4'h1:    p = HP_0125;
      4'h2:    p = HP_025;
      4'h3:    p = HP_05;
      4'h4:    p = HP_1;
      4'h5:    p = HP_2;
      4'h6:    p = HP_4;
      default: p = HP_1;  // codes 7..15 fall back to 1 Hz
    endcase
    return p;
  endfunction : health_period

  // ----------------------------------------
  // wishbone decode
  // ----------------------------------------
  logic [31:0] est_reg;
  logic [31:0] pose_reg;
  logic        ack_reg;
  logic        err_reg;
  logic [31:0] dat_reg;
  logic [NUM_GROUPS-1:0] pend_reg;

  wire        req       = cyc_i && stb_i && !ack_reg && !err_reg;
  wire [7:0]  idx       = adr_i[9:2];
  wire        hit_est   = (idx == REG_IDX_ESTIMATES);
  wire        hit_pose  = (idx == REG_IDX_POSE_STATUS);
  wire        hit_stat  = (idx == REG_IDX_STATUS);
  wire        mapped    = hit_est || hit_pose || hit_stat;
  wire        wr_est    = req && we_i && hit_est;
  wire        wr_pose   = req && we_i && hit_pose;
  wire [31:0] est_next  = byte_merge(est_reg, dat_i, sel_i);
  // reserved bits never store, so they read zero and steer nothing
  wire [31:0] pose_next = byte_merge(pose_reg, dat_i, sel_i) & POSE_STATUS_WMASK;
  wire [31:0] rd_mux    = hit_est  ? est_reg :
                          hit_pose ? pose_reg :
                          hit_stat ? {26'h0, pend_reg} : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      est_reg  <= RST_ESTIMATES;
      pose_reg <= RST_POSE_STATUS;
      ack_reg  <= 1'b0;
      err_reg  <= 1'b0;
      dat_reg  <= 32'h0000_0000;
    end else begin
      ack_reg <= req && mapped;
      err_reg <= req && !mapped;
      if (req) dat_reg <= rd_mux;
      if (wr_est) est_reg <= est_next;
      if (wr_pose) pose_reg <= pose_next;
    end
  end

  assign ack_o = ack_reg;
  assign err_o = err_reg;
  assign dat_o = dat_reg;

  // ----------------------------------------
  // field extraction
  // ----------------------------------------
  wire [7:0] quaternion_broadcast_rate   = est_reg[QUAT_LSB +: 8];
  wire [7:0] euler_rate  = est_reg[EULER_LSB +: 8];
  wire [7:0] posn_rate   = est_reg[POSN_LSB +: 8];
  wire [7:0] velo_rate   = est_reg[VELO_LSB +: 8];
  wire [7:0] pose_rate   = pose_reg[POSE_LSB +: 8];
  wire [3:0] health_code = pose_reg[HEALTH_LSB +: 4];
  wire       pose_on     = (pose_rate != 8'h00);

  // ----------------------------------------
  // time base
  // ----------------------------------------
  logic [15:0] div_reg;
  logic        tick;

  // one-cycle enable at TICK_HZ; all groups share it so they stay in phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= 16'h0000;
      tick    <= 1'b0;
    end else begin
      tick <= (div_reg == 16'(TICK_DIV - 1));
      if (div_reg == 16'(TICK_DIV - 1)) div_reg <= 16'h0000;
      else div_reg <= div_reg + 16'h0001;
    end
  end

  // ----------------------------------------
  // per-group rate generators
  // ----------------------------------------
  logic [NUM_GROUPS-1:0] grp_en;
  logic [15:0]           grp_inc [NUM_GROUPS];
  logic [15:0]           grp_mod [NUM_GROUPS];
  logic [NUM_GROUPS-1:0] grp_fire;

  // a zero rate disables the generator, so it never fires
  assign grp_en[GRP_QUAT]   = (quaternion_broadcast_rate != 8'h00);
  assign grp_en[GRP_EULER]  = (euler_rate != 8'h00) && !pose_on;
  assign grp_en[GRP_POSN]   = (posn_rate != 8'h00) && !pose_on;
  assign grp_en[GRP_VELO]   = (velo_rate != 8'h00);
  assign grp_en[GRP_POSE]   = pose_on;
  assign grp_en[GRP_HEALTH] = (health_code != 4'h0);

  // rate in Hz accumulated per tick against TICK_HZ gives even spacing; health adds 1 per tick against its period
  assign grp_inc[GRP_QUAT]   = {8'h00, quaternion_broadcast_rate};
  assign grp_inc[GRP_EULER]  = {8'h00, euler_rate};
  assign grp_inc[GRP_POSN]   = {8'h00, posn_rate};
  assign grp_inc[GRP_VELO]   = {8'h00, velo_rate};
  assign grp_inc[GRP_POSE]   = {8'h00, pose_rate};
  assign grp_inc[GRP_HEALTH] = 16'h0001;
  assign grp_mod[GRP_QUAT]   = 16'(TICK_HZ);
  assign grp_mod[GRP_EULER]  = 16'(TICK_HZ);
  assign grp_mod[GRP_POSN]   = 16'(TICK_HZ);
  assign grp_mod[GRP_VELO]   = 16'(TICK_HZ);
  assign grp_mod[GRP_POSE]   = 16'(TICK_HZ);
  assign grp_mod[GRP_HEALTH] = health_period(health_code);

  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_rate
    trs_rate_gen #(
      .ACC_W (16)
    ) u_gen (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .tick_i (tick),
      .inc_i  (grp_inc[g]),
      .mod_i  (grp_mod[g]),
      .en_i   (grp_en[g]),
      .fire_o (grp_fire[g])
    );
  end

  // ----------------------------------------
  // pending queue and selection
  // ----------------------------------------
  // one pending bit per group: a request that finds its bit still set is
  // merged, a trade of exact count for a tiny queue when the framer stalls
  logic [NUM_GROUPS-1:0] sel_onehot;
  logic [NUM_GROUPS-1:0] take;
  logic [NUM_GROUPS-1:0] shown_reg;
  wire                   pend_any = |pend_reg;

  // fixed priority, lowest group index first
  assign sel_onehot = pend_reg & (~pend_reg + 6'h01);
  // clear the group on show, not the current head: a higher group that
  // fires during a stall must not be retired by the older descriptor
  assign take       = (pkt_valid_o && pkt_ready_i) ? shown_reg : 6'h00;

  // a new request wins over the clear of the same bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_reg <= 6'h00;
    end else begin
      pend_reg <= ((pend_reg & ~take) | grp_fire) & grp_en;
    end
  end

  // ----------------------------------------
  // descriptor output
  // ----------------------------------------
  logic [7:0] addr_next;
  logic [3:0] len_next;
  logic       batch_next;

  always_comb begin
    addr_next  = ADDR_QUAT;
    len_next   = LEN_QUAT;
    batch_next = 1'b1;
    if (sel_onehot[GRP_EULER]) begin
      addr_next = ADDR_EULER;
      len_next  = LEN_EULER;
    end else if (sel_onehot[GRP_POSN]) begin
      addr_next = ADDR_POSN;
      len_next  = LEN_POSN;
    end else if (sel_onehot[GRP_VELO]) begin
      addr_next = ADDR_VELO;
      len_next  = LEN_VELO;
    end else if (sel_onehot[GRP_POSE]) begin
      addr_next = ADDR_POSE;
      len_next  = LEN_POSE;
    end else if (sel_onehot[GRP_HEALTH]) begin
      addr_next  = ADDR_HEALTH;
      len_next   = LEN_HEALTH;
      batch_next = 1'b0;
    end
  end

  // data outputs registered; they follow the head of the queue except while valid is high and ready is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pkt_addr_o  <= 8'h00;
      pkt_len_o   <= 4'h0;
      pkt_batch_o <= 1'b0;
      shown_reg   <= 6'h00;
    end else if (!pkt_valid_o || pkt_ready_i) begin
      shown_reg   <= sel_onehot;
      pkt_addr_o  <= addr_next;
      pkt_len_o   <= len_next;
      pkt_batch_o <= batch_next;
    end
  end

  // valid only once the descriptor registers hold the head entry
  logic vld_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) vld_reg <= 1'b0;
    else if (!pkt_valid_o || pkt_ready_i) vld_reg <= pend_any && !(|take);
  end
  // a shown group that was disabled meanwhile withdraws its descriptor
  assign pkt_valid_o = vld_reg && (|(pend_reg & shown_reg));

endmodule : trs_scheduler

// file: trs_scheduler_sva.sv
/*
 checker for the telemetry rate scheduler: bus answers and descriptors.
 assumes it is bound into trs_scheduler and sees only its ports.
*/
module trs_scheduler_sva (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // bus
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  input wire logic       err_o,
  // descriptor stream
  input wire logic       pkt_valid_o,
  input wire logic       pkt_ready_i,
  input wire logic [7:0] pkt_addr_o,
  input wire logic [3:0] pkt_len_o,
  input wire logic       pkt_batch_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_answer;
    cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o;
  endproperty
  a_answer: assert property (p_answer) else $error("no bus answer");
  property p_pulse;
    ack_o || err_o |=> !ack_o && !err_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("answer too long");
  property p_hold;
    pkt_valid_o && !pkt_ready_i |=> pkt_valid_o && $stable({pkt_addr_o, pkt_len_o, pkt_batch_o});
  endproperty
  a_hold: assert property (p_hold) else $error("descriptor changed");
  property p_gap;
    pkt_valid_o && pkt_ready_i |=> !pkt_valid_o;
  endproperty
  a_gap: assert property (p_gap) else $error("no gap after accept");
  property p_quat;
    pkt_valid_o && pkt_addr_o == 8'h6D |-> pkt_len_o == 4'h3 && pkt_batch_o;
  endproperty
  a_quat: assert property (p_quat) else $error("bad quaternion packet");
  property p_at112;
    pkt_valid_o && pkt_addr_o == 8'h70 |-> pkt_batch_o && pkt_len_o inside {4'h5, 4'h9};
  endproperty
  a_at112: assert property (p_at112) else $error("bad packet at 112");
  property p_posn;
    pkt_valid_o && pkt_addr_o == 8'h75 |-> pkt_len_o == 4'h4 && pkt_batch_o;
  endproperty
  a_posn: assert property (p_posn) else $error("bad position packet");
  property p_velo;
    pkt_valid_o && pkt_addr_o == 8'h79 |-> pkt_len_o == 4'h4 && pkt_batch_o;
  endproperty
  a_velo: assert property (p_velo) else $error("bad velocity packet");
  property p_health;
    pkt_valid_o && !pkt_batch_o |-> pkt_addr_o == 8'h55 && pkt_len_o == 4'h1;
  endproperty
  a_health: assert property (p_health) else $error("bad health packet");

  c_health: cover property (pkt_valid_o && pkt_ready_i && !pkt_batch_o);
  c_pose: cover property (pkt_valid_o && pkt_ready_i && pkt_len_o == 4'h9);
  c_err: cover property (err_o);
endmodule : trs_scheduler_sva

bind trs_scheduler trs_scheduler_sva u_sva (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .err_o,
  .pkt_valid_o, .pkt_ready_i, .pkt_addr_o, .pkt_len_o, .pkt_batch_o);
